// [hw/usb_function_status_irq.sv]
`timescale 1ns/1ps
// Function
// (R1) stall persists until cleared plus clear feature
// (R2) rmw read of stall zero under autoclear
// (R3) endpoints 2-5 bits 8:7 read zero
// (R4) packet size 9 bits ep1, 7 bits others
// (R5) software avoids zero, oversize, tiny dma sizes
// (R6) software prefers even packet sizes
// (R7) frame number captured on sof, soft reset clears
// (R8) flags except setup request interrupts when enabled
// (R9) flags clear on written zero, rmw reads one
// (R10) suspend entry sets status bit 5
// (R11) sof sets status bit 4 with frame
// (R12) bus reset sets status bit 3
// (R13) software reinitialises buffers after bus reset
// (R14) host resume sets bit 2 unless remote wake
// (R15) setup stage sets bit 1, never interrupts; the code leaves bit 1 clear for a setup flagged setup_auto
// (R16) set configuration sets status bit 0
// (R17) enables at bits 13..10 and 8, reset zero
// (R18) configuration index bit 9 follows config event
// (R19) enable bits 15:14 read zero
// (R20) send buffer init resets one, forced by soft reset
// (R21) buffer init sets send buffer free flag
// (R22) free flag set means nak to in requests
// (R23) interrupt while any enabled source pending
module usb_function_status_irq (
  // clock and reset
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // axi4-lite write
  input  wire logic [6:0]            awaddr,
  input  wire logic                  awvalid,
  output logic                       awready,
  input  wire logic [31:0]           wdata,
  input  wire logic [3:0]            wstrb,
  input  wire logic                  wvalid,
  output logic                       wready,
  output logic [1:0]                 bresp,
  output logic                       bvalid,
  input  wire logic                  bready,
  // axi4-lite read
  input  wire logic [6:0]            araddr,
  input  wire logic                  arvalid,
  output logic                       arready,
  output logic [31:0]                rdata,
  output logic [1:0]                 rresp,
  output logic                       rvalid,
  input  wire logic                  rready,
  // protocol engine side
  input  wire usb_fn_pkg::usb_events_s ev,
  output logic [5:1]                 ep_stall_resp,
  output logic                       ep0_in_nak,
  output logic                       irq
);

  logic [6:0]        waddr_q;
  logic [15:0]       wdata_q;
  logic [1:0]        wstrb_q;
  logic [15:0]       wm;
  logic              do_write;
  logic [15:0]       ctrl_reg;
  logic [10:0]       frame_reg;
  logic [5:0]        status_reg;
  logic [15:0]       irq_en_reg;
  logic              configured_flag_index_reg;
  logic              buf_init_reg;
  logic              free_en_reg;
  logic [5:1]        stall_reg;
  logic [5:1]        dma_reg;
  logic [8:0]        mps_reg [1:5];
  logic [15:0]       ep_word [1:5];
  logic [15:0]       ep_next [1:5];
  logic [5:1]        wr_ep;
  logic [5:1]        cf_hit;
  logic [5:0]        st_set;
  logic [5:0]        st_clr;
  logic [5:0]        src_en;
  logic [15:0]       rd_val;
  logic              rd_ok;
  logic              soft_reset;
  logic              stall_auto;
  logic              wr_ctrl;
  logic              wr_status;
  logic              wr_ie;
  logic              wr_e0;

  function automatic logic reg_hit(input logic [6:0] a,
                                   input logic [6:0] o);
    return a[5:2] == o[5:2];
  endfunction

  function automatic logic mapped(input logic [6:0] a);
    return a[5:2] <= usb_fn_pkg::OFS_EP5[5:2];
  endfunction

  function automatic logic [6:0] ep_ofs(input int i);
    return 7'(usb_fn_pkg::OFS_EP1 + usb_fn_pkg::EP_STEP * (i - 1));
  endfunction

  assign soft_reset = ctrl_reg[usb_fn_pkg::CTRL_SOFT_RESET];
  assign stall_auto = ctrl_reg[usb_fn_pkg::CTRL_STALL_AUTO];
  assign wm         = {{8{wstrb_q[1]}},
                       {8{wstrb_q[0]}}};
  assign do_write   = !awready && !wready && !bvalid;
  assign wr_ctrl    = do_write && reg_hit(waddr_q, usb_fn_pkg::OFS_CTRL);
  assign wr_status  = do_write && reg_hit(waddr_q, usb_fn_pkg::OFS_STATUS);
  assign wr_ie      = do_write && reg_hit(waddr_q, usb_fn_pkg::OFS_IRQ_EN);
  assign wr_e0      = do_write && reg_hit(waddr_q, usb_fn_pkg::OFS_EP0_IN);

  // write address and data are taken independently
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      waddr_q <= 7'h00;
    end else if (awvalid && awready) begin
      awready <= 1'b0;
      waddr_q <= awaddr;
    end else if (do_write) begin
      awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready  <= 1'b1;
      wdata_q <= 16'h0000;
      wstrb_q <= 2'h0;
    end else if (wvalid && wready) begin
      wready  <= 1'b0;
      wdata_q <= wdata[15:0];
      wstrb_q <= wstrb[1:0];
    end else if (do_write) begin
      wready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= usb_fn_pkg::RESP_OKAY;
    end else if (do_write) begin
      bvalid <= 1'b1;
      bresp  <= mapped(waddr_q) ? usb_fn_pkg::RESP_OKAY
                                : usb_fn_pkg::RESP_SLVERR;
    end else if (bvalid && bready) begin
      bvalid <= 1'b0;
    end
  end

  // read mux; the alias bit gives the rmw view
  always_comb begin
    logic rmw;
    rmw    = araddr[usb_fn_pkg::RMW_BIT];
    rd_val = 16'h0000;
    rd_ok  = 1'b1;
    if (reg_hit(araddr, usb_fn_pkg::OFS_CTRL)) begin
      rd_val = ctrl_reg;
    end else if (reg_hit(araddr, usb_fn_pkg::OFS_FRAME)) begin
      rd_val = {5'h00, frame_reg};
    end else if (reg_hit(araddr, usb_fn_pkg::OFS_STATUS)) begin
      rd_val = {10'h000, rmw ? 6'h3f : status_reg}; // R9
    end else if (reg_hit(araddr, usb_fn_pkg::OFS_IRQ_EN)) begin
      rd_val = irq_en_reg; // R19
      rd_val[usb_fn_pkg::IE_CONFIGURED_FLAG_INDEX] = configured_flag_index_reg; // R18
    end else if (reg_hit(araddr, usb_fn_pkg::OFS_EP0_IN)) begin
      rd_val[usb_fn_pkg::E0_BUF_INIT] = buf_init_reg;
      rd_val[usb_fn_pkg::E0_FREE_EN]  = free_en_reg;
      rd_val[usb_fn_pkg::E0_FREE]     = rmw | ep0_in_nak;
    end else begin
      rd_ok = 1'b0;
      for (int i = 1; i <= 5; i++) begin
        if (reg_hit(araddr, ep_ofs(i))) begin
          rd_val = ep_word[i];
          rd_val[usb_fn_pkg::EPC_STALL] = stall_reg[i] &
                                          !(rmw && stall_auto); // R2
          rd_ok  = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h00000000;
      rresp   <= usb_fn_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= {16'h0000, rd_val};
      rresp   <= rd_ok ? usb_fn_pkg::RESP_OKAY : usb_fn_pkg::RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= usb_fn_pkg::CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_reg <= (ctrl_reg & ~(wm & usb_fn_pkg::CTRL_WMASK)) |
                  (wdata_q & wm & usb_fn_pkg::CTRL_WMASK);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || soft_reset) begin
      frame_reg <= 11'h000; // R7
    end else if (ev.sof) begin
      frame_reg <= ev.frame; // R7 R11
    end
  end

  always_comb begin
    st_set = 6'h00;
    st_set[usb_fn_pkg::ST_SUSPEND] = ev.suspend_enter; // R10
    st_set[usb_fn_pkg::ST_SOF]     = ev.sof; // R11
    st_set[usb_fn_pkg::ST_BUS_RST] = ev.bus_reset; // R12
    st_set[usb_fn_pkg::ST_RESUME]  = ev.host_resume &&
      !ctrl_reg[usb_fn_pkg::CTRL_REMOTE_WAKE]; // R14
    st_set[usb_fn_pkg::ST_SETUP]   = ev.setup_rx && !ev.setup_auto; // R15
    st_set[usb_fn_pkg::ST_CONFIG]  = ev.config_done; // R16
    st_clr = wr_status ? (wm[5:0] & ~wdata_q[5:0]) : 6'h00; // R9
  end

  // hardware set wins over a software clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn || soft_reset) begin
      status_reg <= 6'h00;
    end else begin
      status_reg <= (status_reg & ~st_clr) | st_set; // R9
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || soft_reset) begin
      irq_en_reg <= usb_fn_pkg::IE_RESET; // R17
    end else if (wr_ie) begin
      irq_en_reg <= (irq_en_reg & ~(wm & usb_fn_pkg::IE_WMASK)) |
                    (wdata_q & wm & usb_fn_pkg::IE_WMASK); // R17 R19
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || soft_reset) begin
      configured_flag_index_reg <= 1'b0;
    end else if (ev.config_done) begin
      configured_flag_index_reg <= ev.config_index; // R18
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || soft_reset) begin
      buf_init_reg <= 1'b1; // R20
    end else if (wr_e0 && wm[15]) begin
      buf_init_reg <= wdata_q[usb_fn_pkg::E0_BUF_INIT];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      free_en_reg <= 1'b0;
    end else if (wr_e0 && wm[15]) begin
      free_en_reg <= wdata_q[usb_fn_pkg::E0_FREE_EN];
    end
  end

  // free flag doubles as the automatic nak for ep0 in
  always_ff @(posedge aclk) begin
    if (!aresetn || buf_init_reg) begin
      ep0_in_nak <= 1'b1; // R21 R22
    end else if (ev.ep0_in_done) begin
      ep0_in_nak <= 1'b1;
    end else if (wr_e0 && wm[15] && !wdata_q[usb_fn_pkg::E0_FREE]) begin
      ep0_in_nak <= 1'b0; // R22
    end
  end

  always_comb begin
    for (int i = 1; i <= 5; i++) begin
      ep_word[i] = {4'h0, dma_reg[i], 1'b0, stall_reg[i], mps_reg[i]};
      ep_next[i] = (ep_word[i] & ~wm) | (wdata_q & wm);
      wr_ep[i]   = do_write && reg_hit(waddr_q, ep_ofs(i));
      cf_hit[i]  = ev.clear_feature && ev.clear_ep == 3'(i);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stall_reg <= 5'h00;
      dma_reg   <= 5'h00;
      mps_reg[1] <= usb_fn_pkg::MPS_EP1_RESET;
      for (int i = 2; i <= 5; i++) begin
        mps_reg[i] <= usb_fn_pkg::MPS_EPN_RESET;
      end
    end else begin
      for (int i = 1; i <= 5; i++) begin
        if (cf_hit[i] && stall_auto) begin
          stall_reg[i] <= 1'b0; // R1
        end
        if (wr_ep[i]) begin
          stall_reg[i] <= ep_next[i][usb_fn_pkg::EPC_STALL];
          dma_reg[i]   <= ep_next[i][usb_fn_pkg::EPC_DMA];
          mps_reg[i]   <= (i == 1) ? ep_next[i][8:0] :
                          ep_next[i][8:0] & usb_fn_pkg::MPS_EPN_MASK; // R3 R4
        end
      end
    end
  end

  // stall answer lasts until the bit is gone and clear feature arrives
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ep_stall_resp <= 5'h00;
    end else begin
      for (int i = 1; i <= 5; i++) begin
        if (cf_hit[i] && (stall_auto || !stall_reg[i])) begin
          ep_stall_resp[i] <= 1'b0; // R1
        end else if (stall_reg[i]) begin
          ep_stall_resp[i] <= 1'b1; // R1
        end
      end
    end
  end

  assign src_en = {irq_en_reg[13:10], 1'b0, irq_en_reg[8]}; // R8

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_reg & src_en) | (ep0_in_nak & free_en_reg); // R23
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_stall_holds: assert property ( // R1
    stall_reg[1] && !(cf_hit[1] && stall_auto) |=> ep_stall_resp[1])
    else $error("stall answer missing");
  a_stall_exit: assert property ( // R1
    $fell(ep_stall_resp[1]) |-> $past(cf_hit[1]))
    else $error("stall answer left without clear feature");
  a_ep_reserved: assert property ( // R3
    mps_reg[2][8:7] == 2'h0 && mps_reg[5][8:7] == 2'h0)
    else $error("reserved packet size bits set");
  a_frame_capture: assert property ( // R7
    ev.sof && !soft_reset |=> frame_reg == $past(ev.frame) &&
      status_reg[usb_fn_pkg::ST_SOF])
    else $error("frame number not captured");
  a_flag_sticky: assert property ( // R9
    status_reg[usb_fn_pkg::ST_BUS_RST] && !soft_reset &&
      !st_clr[usb_fn_pkg::ST_BUS_RST] |=>
      status_reg[usb_fn_pkg::ST_BUS_RST])
    else $error("bus reset flag lost");
  a_bus_reset_set: assert property ( // R12
    ev.bus_reset && !soft_reset |=> status_reg[usb_fn_pkg::ST_BUS_RST])
    else $error("bus reset not flagged");
  a_resume_gate: assert property ( // R14
    $rose(status_reg[usb_fn_pkg::ST_RESUME]) |->
      $past(ev.host_resume && !ctrl_reg[usb_fn_pkg::CTRL_REMOTE_WAKE]))
    else $error("resume flag without host resume");
  a_setup_quiet: assert property ( // R15
    status_reg == 6'h02 && !(ep0_in_nak && free_en_reg) |=> !irq)
    else $error("setup flag raised interrupt");
  a_configured_flag_index: assert property ( // R18
    ev.config_done && !soft_reset |=>
      configured_flag_index_reg == $past(ev.config_index) &&
      status_reg[usb_fn_pkg::ST_CONFIG])
    else $error("configuration index not updated");
  a_buf_init: assert property ( // R20
    soft_reset |=> buf_init_reg ##1 ep0_in_nak)
    else $error("soft reset did not init send buffer");
  a_irq_follow: assert property ( // R23
    |(status_reg & src_en) |=> irq)
    else $error("interrupt not raised");

  c_sof_irq: cover property (ev.sof ##1 irq);
  c_stall_exit: cover property (ep_stall_resp[1] ##1 !ep_stall_resp[1]);
  c_flag_clear: cover property ($fell(status_reg[usb_fn_pkg::ST_SUSPEND]));
  c_free_irq: cover property (ep0_in_nak && free_en_reg ##1 irq);

endmodule // usb_function_status_irq

// [hw/usb_fn_pkg.sv]
package usb_fn_pkg;

  // register byte offsets; bit 6 of the address selects the rmw view
  localparam logic [6:0] OFS_CTRL   = 7'h00;
  localparam logic [6:0] OFS_FRAME  = 7'h04;
  localparam logic [6:0] OFS_STATUS = 7'h08;
  localparam logic [6:0] OFS_IRQ_EN = 7'h0c;
  localparam logic [6:0] OFS_EP0_IN = 7'h10;
  localparam logic [6:0] OFS_EP1    = 7'h14;
  localparam logic [6:0] OFS_EP5    = 7'h24;
  localparam int         EP_STEP    = 4;
  localparam int         RMW_BIT    = 6;

  // controller_control_reg
  localparam int          CTRL_SOFT_RESET = 7;
  localparam int          CTRL_REMOTE_WAKE = 5;
  localparam int          CTRL_STALL_AUTO = 3;
  localparam logic [15:0] CTRL_WMASK = 16'h00a8;
  localparam logic [15:0] CTRL_RESET = 16'h0080;

  // bus_event_status
  localparam int ST_SUSPEND = 5;
  localparam int ST_SOF     = 4;
  localparam int ST_BUS_RST = 3;
  localparam int ST_RESUME  = 2;
  localparam int ST_SETUP   = 1;
  localparam int ST_CONFIG  = 0;
  localparam int ST_W       = 6;

  // bus_event_irq_enable
  localparam int          IE_CONFIGURED_FLAG_INDEX = 9;
  localparam logic [15:0] IE_WMASK = 16'h3d00;
  localparam logic [15:0] IE_RESET = 16'h0000;
  localparam int          IE_SHIFT = 8;

  // ep0_in_status
  localparam int          E0_BUF_INIT = 15;
  localparam int          E0_FREE_EN  = 14;
  localparam int          E0_FREE     = 10;

  // endpoint 1..5 control
  localparam int          EPC_DMA    = 11;
  localparam int          EPC_STALL  = 9;
  localparam int          MPS_W      = 9;
  localparam logic [8:0]  MPS_EP1_RESET = 9'h100;
  localparam logic [8:0]  MPS_EPN_RESET = 9'h040;
  localparam logic [8:0]  MPS_EPN_MASK  = 9'h07f;

  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // one-cycle event pulses from the usb protocol engine
  typedef struct packed {
    logic        sof;
    logic [10:0] frame;
    logic        suspend_enter;
    logic        bus_reset;
    logic        host_resume;
    logic        setup_rx;
    logic        setup_auto;
    logic        config_done;
    logic        config_index;
    logic        clear_feature;
    logic [2:0]  clear_ep;
    logic        ep0_in_done;
  } usb_events_s;

endpackage

// [tb/usb_engine_model.sv]
`timescale 1ns/1ps
module usb_engine_model (
  // clock
  input  wire logic                    aclk,
  // command from the bench
  input  wire logic                    go,
  input  wire logic [1:0]              lag,
  input  wire usb_fn_pkg::usb_events_s cmd,
  // toward the device
  output usb_fn_pkg::usb_events_s      ev,
  output logic                         busy
);
  usb_fn_pkg::usb_events_s hold_reg;
  logic [1:0]              cnt_reg;

  initial begin
    busy = 1'b0;
    cnt_reg = 2'h0;
    hold_reg = '0;
  end

  // prompt or late answer, as the bench asks
  always @(posedge aclk) begin
    if (go) begin
      hold_reg <= cmd;
      cnt_reg <= lag;
      busy <= 1'b1;
    end else if (cnt_reg != 2'h0) begin
      cnt_reg <= cnt_reg - 2'h1;
    end else begin
      busy <= 1'b0;
    end
  end

  // one-cycle pulse; qualifiers scrambled outside it
  always_comb begin
    ev = '0;
    ev.frame = ~hold_reg.frame;
    ev.config_index = ~hold_reg.config_index;
    ev.clear_ep = ~hold_reg.clear_ep;
    if (busy && cnt_reg == 2'h0) begin
      ev = hold_reg;
    end
  end
endmodule // usb_engine_model

// [tb/tb_usb_function_status_irq.sv]
`timescale 1ns/1ps
module tb_usb_function_status_irq;
  logic                    aclk = 1'b0;
  logic                    aresetn = 1'b0;
  logic [6:0]              awaddr = 7'h00;
  logic [6:0]              araddr = 7'h00;
  logic                    awvalid = 1'b0;
  logic                    wvalid = 1'b0;
  logic                    arvalid = 1'b0;
  logic [31:0]             wdata = 32'h0;
  logic [3:0]              wstrb = 4'hf;
  logic                    awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0]              bresp, rresp, rs;
  logic [1:0]              exp_resp = 2'h0;
  logic [31:0]             rdata;
  logic [5:1]              stall_resp;
  logic                    nak, busy;
  logic                    go = 1'b0;
  logic                    configuration_index = 1'b0;
  logic [1:0]              lag = 2'h0;
  usb_fn_pkg::usb_events_s ev;
  usb_fn_pkg::usb_events_s cmd = '0;
  int                      err_total = 0;
  int                      samples_checked = 0;
  int                      cyc = 0;
  int                      k;
  logic [15:0]             rd, ie, ex;
  logic [10:0]             fr;

  always #12.5 aclk = ~aclk;

  usb_function_status_irq dut_u (
    .aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(1'b1),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(1'b1),
    .ev(ev), .ep_stall_resp(stall_resp), .ep0_in_nak(nak), .irq(irq)
  );

  usb_engine_model host_u (
    .aclk(aclk), .go(go), .lag(lag), .cmd(cmd), .ev(ev), .busy(busy)
  );

  task automatic give_verdict();
    $display("err_total=%0d samples_checked=%0d", err_total,
             samples_checked);
    if (err_total == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    awaddr <= a;
    wdata <= {16'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (awready && !ad) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready && !wd) begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!bvalid);
    cmp(bresp, exp_resp);
  endtask

  task automatic rc(input logic [6:0] a, input logic [15:0] e);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    rd = rdata[15:0];
    rs = rresp;
    cmp(rdata[31:16], 16'h0000);
    cmp(rs, exp_resp);
    if (a != 7'h3c)
      cmp(rd, e);
  endtask

  // 0 config, 1 setup, 2 resume, 3 bus reset, 4 sof, 5 suspend,
  // 6 clear, 7 automatic setup, 8 ep0 in sent
  task automatic fire(input int kk, input logic [10:0] f, input logic c);
    usb_fn_pkg::usb_events_s e;
    e = '0;
    e.frame = f;
    e.config_index = c;
    e.clear_ep = f[2:0];
    case (kk)
      0: e.config_done = 1'b1;
      1: e.setup_rx = 1'b1;
      2: e.host_resume = 1'b1;
      3: e.bus_reset = 1'b1;
      4: e.sof = 1'b1;
      5: e.suspend_enter = 1'b1;
      7: begin
        e.setup_rx = 1'b1;
        e.setup_auto = 1'b1;
      end
      8: e.ep0_in_done = 1'b1;
      default: e.clear_feature = 1'b1;
    endcase
    cmd <= e;
    lag <= 2'($urandom);
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
    do @(posedge aclk); while (busy);
    repeat (2) @(posedge aclk);
  endtask

  function automatic logic irq_of(input logic [15:0] st, input logic [15:0] en);
    return |(st[5:0] & {en[13:10], 1'b0, en[8]});
  endfunction

  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      give_verdict();
    end
  end

  initial begin
    k = $urandom(63);
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rc(7'h00, 16'h0080);
    rc(7'h0c, 16'h0000);
    rc(7'h10, 16'h8400);
    rc(7'h14, 16'h0100);
    rc(7'h18, 16'h0040);
    cmp(nak, 1'b1);
    fire(4, 11'h5a5, 1'b1);
    rc(7'h04, 16'h0000);
    rc(7'h08, 16'h0000);
    wr(7'h00, 16'h0000);
    for (int i = 0; i < 14; i++) begin
      k = (i < 6) ? i : $urandom_range(5);
      fr = 11'($urandom);
      ie = 16'($urandom) & 16'h3f00;
      wr(7'h0c, ie);
      fire(k, fr, fr[3]);
      if (k == 0)
        configuration_index = fr[3];
      ex = 16'h1 << k;
      rc(7'h08, ex);
      cmp(irq, irq_of(ex, ie));
      if (k == 4)
        rc(7'h04, {5'h0, fr});
      rc(7'h0c, (ie & 16'h3d00) | {6'h0, configuration_index, 9'h0});
      rc(7'h48, 16'h003f);
      wr(7'h08, 16'h003f);
      rc(7'h08, ex);
      wr(7'h08, ~ex);
      rc(7'h08, 16'h0000);
      cmp(irq, 1'b0);
      if (k == 3) begin
        wr(7'h10, 16'h8000);
        rc(7'h10, 16'h8400);
        cmp(nak, 1'b1);
        wr(7'h10, 16'h0400);
        wr(7'h10, 16'h0000);
        rc(7'h10, 16'h0000);
        cmp(nak, 1'b0);
      end
    end
    fire(7, 11'h0, 1'b0);
    rc(7'h08, 16'h0000);
    wr(7'h10, 16'h4400);
    fire(8, 11'h0, 1'b0);
    cmp(nak, 1'b1);
    cmp(irq, 1'b1);
    wr(7'h10, 16'h4000);
    rc(7'h10, 16'h4000);
    cmp(nak, 1'b0);
    cmp(irq, 1'b0);
    wr(7'h10, 16'h0400);
    wr(7'h00, 16'h0020);
    fire(2, 11'h0, 1'b0);
    rc(7'h08, 16'h0000);
    wr(7'h00, 16'h0000);
    for (int n = 1; n <= 5; n++) begin
      ex = 16'h0a00 | 16'(2 * $urandom_range(n == 1 ? 128 : 32, 2));
      wr(7'h10 + 7'(4 * n), ex);
      rc(7'h10 + 7'(4 * n), ex);
      rc(7'h50 + 7'(4 * n), ex);
      cmp(stall_resp[n], 1'b1);
      fire(6, 11'(n), 1'b0);
      cmp(stall_resp[n], 1'b1);
      wr(7'h10 + 7'(4 * n), ex & 16'h01ff);
      cmp(stall_resp[n], 1'b1);
      fire(6, 11'(n), 1'b0);
      cmp(stall_resp[n], 1'b0);
    end
    exp_resp = usb_fn_pkg::RESP_SLVERR;
    wr(7'h28, 16'hffff);
    rc(7'h3c, 16'h0000);
    exp_resp = usb_fn_pkg::RESP_OKAY;
    wr(7'h00, 16'h0088);
    fire(5, 11'h0, 1'b0);
    rc(7'h10, 16'h8400);
    rc(7'h08, 16'h0000);
    wr(7'h00, 16'h0008);
    wstrb <= 4'h1;
    wr(7'h0c, 16'h3d00);
    wstrb <= 4'hf;
    rc(7'h0c, 16'h0000);
    wr(7'h1c, 16'h0240);
    rc(7'h1c, 16'h0240);
    rc(7'h5c, 16'h0040);
    fire(6, 11'h3, 1'b0);
    rc(7'h1c, 16'h0040);
    cmp(stall_resp[3], 1'b0);
    give_verdict();
  end
endmodule // tb_usb_function_status_irq
